// File: pkg/player_pkg.sv
package player_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int SAMPLE_HZ = 16;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int LONG_MS = 1000;
    localparam int POWER_MS = 2000;
    localparam int RESTART_MS = 5000;
    localparam int PAUSE_LP_MS = 3000;
    localparam int BLINK_MS = 250;
    localparam logic [7:0] LONG_SMP = 8'(LONG_MS * SAMPLE_HZ / 1000);
    localparam logic [7:0] POWER_SMP = 8'(POWER_MS * SAMPLE_HZ / 1000);
    localparam logic [7:0] RESTART_SMP = 8'(RESTART_MS * SAMPLE_HZ / 1000);
    localparam logic [7:0] PAUSE_LP_SMP = 8'(PAUSE_LP_MS * SAMPLE_HZ / 1000);
    localparam logic [7:0] BLINK_SMP = 8'(BLINK_MS * SAMPLE_HZ / 1000);
    localparam logic [7:0] CNT_MAX = 8'hff;
    // ==========================================================
    // Keys and levels
    localparam int NKEYS = 6;
    localparam int K_VDN = 0;
    localparam int K_VUP = 1;
    localparam int K_PREV = 2;
    localparam int K_NEXT = 3;
    localparam int K_FEAT = 4;
    localparam int K_PWR = 5;
    localparam logic [7:0] VOL_RESET = 8'hc0;
    localparam logic [7:0] VOL_MAX = 8'hff;
    localparam logic [7:0] VOL_MIN = 8'h00;
    localparam logic [7:0] MONITOR_BYTE = 8'hef;
    localparam logic [15:0] RATE_CLAMP = 16'hb71b;
    localparam logic [15:0] RATE_RESET = 16'hac44;
    localparam logic [7:0] GAIN_DEFAULT = 8'hf4;
    // ==========================================================
    // Register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_VOLUME = 8'h08;
    localparam logic [7:0] A_RXBYTE = 8'h0c;
    localparam logic [7:0] A_RATE = 8'h10;
    localparam logic [7:0] A_GAIN = 8'h14;
    localparam logic [7:0] A_PLAYTIME = 8'h18;
    localparam int C_BOOT_DONE = 0;
    localparam int C_FLASH_BUSY = 1;
    localparam int C_SECTOR_OK = 2;
    localparam int C_CLK12 = 3;
    localparam int C_TAG_VALID = 4;
    localparam int C_MON_CLR = 5;
    localparam int C_WIDTH = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // ==========================================================
    // Types
    typedef enum logic [2:0] {ST_BOOT, ST_PLAY, ST_PAUSE, ST_LOWPWR, ST_USB} play_state_t;
    typedef enum logic [1:0] {SP_OFF, SP_MIN, SP_NORM, SP_EXT} spatial_t;
    typedef struct packed {
        logic prev_song;
        logic next_song;
        logic restart_song;
        logic rewind;
        logic fast_fwd;
        logic random_pick;
        logic power_down;
        logic stop_play;
        logic usb_init;
    } action_t;
endpackage

// File: core/player_control_front_end.sv
`timescale 1ns/1ps
module player_control_front_end #(
    parameter int SAMPLE_DIV = player_pkg::SAMPLE_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] key_input_lines,
    input wire logic power_key,
    input wire logic usb_attach_det,
    input wire logic usb_class_strap_pin,
    input wire logic flash_select_strap,
    output logic power_led,
    output logic feature_led,
    output logic usb_pullup_en,
    output logic clk_48m_sel,
    output logic avdd_3v6_sel,
    output logic usb_audio_class,
    output logic use_flash_disk,
    output logic monitor_mode,
    output logic low_power,
    output logic [7:0] volume,
    output logic [1:0] spatial_mode,
    output logic [15:0] play_rate,
    output logic [7:0] applied_gain,
    output player_pkg::action_t act
);
    // ==========================================================
    // Sample tick
    logic [31:0] div_r;
    logic tick;
    logic [player_pkg::C_WIDTH:0] ctrl_r;
    logic flash_busy;
    logic apb_wr;
    assign flash_busy = ctrl_r[player_pkg::C_FLASH_BUSY];
    assign tick = (div_r == 32'(SAMPLE_DIV - 1)) && !flash_busy;

    // Divider from core clock to the key sampling rate
    always_ff @(posedge core_clk) begin
        if (rst || div_r == 32'(SAMPLE_DIV - 1)) begin
            div_r <= 32'h0;
        end else begin
            div_r <= div_r + 32'h1;
        end
    end

    // ==========================================================
    // Key classification
    logic [player_pkg::NKEYS-1:0] key_lvl_r;
    logic [player_pkg::NKEYS-1:0] short_p;
    logic [player_pkg::NKEYS-1:0] long_p;
    logic [player_pkg::NKEYS-1:0] long_held;
    logic [7:0] held_r [player_pkg::NKEYS];

    // Samples taken only on tick, so bus traffic on the lines is ignored
    always_ff @(posedge core_clk) begin
        if (rst) begin
            key_lvl_r <= '0;
        end else if (tick) begin
            key_lvl_r <= {power_key, key_input_lines};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < player_pkg::NKEYS; gi++) begin : g_key
            // Hold time in samples, saturating
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    held_r[gi] <= 8'h00;
                end else if (tick) begin
                    if (!key_lvl_r[gi]) begin
                        held_r[gi] <= 8'h00;
                    end else if (held_r[gi] != player_pkg::CNT_MAX) begin
                        held_r[gi] <= held_r[gi] + 8'h01;
                    end
                end
            end
            // Short on release before threshold, long once it elapses
            assign short_p[gi] = tick && !key_lvl_r[gi] && held_r[gi] != 8'h00
                && held_r[gi] < player_pkg::LONG_SMP;
            assign long_p[gi] = tick && key_lvl_r[gi]
                && held_r[gi] == player_pkg::LONG_SMP - 8'h01;
            assign long_held[gi] = key_lvl_r[gi] && held_r[gi] >= player_pkg::LONG_SMP;
        end
    endgenerate

    // ==========================================================
    // Player state
    player_pkg::play_state_t state_r;
    logic [7:0] pause_cnt_r;
    logic [7:0] play_time_r;
    logic [7:0] blink_cnt_r;
    logic blink_r;
    logic usb_det_r;
    logic usb_active_r;
    logic random_r;
    logic boot_done;
    logic power_off_p;
    logic song_change;
    assign boot_done = ctrl_r[player_pkg::C_BOOT_DONE];
    assign power_off_p = tick && key_lvl_r[player_pkg::K_PWR]
        && held_r[player_pkg::K_PWR] == player_pkg::POWER_SMP - 8'h01;
    assign song_change = act.prev_song || act.next_song || act.restart_song || act.random_pick;

    // Main play / pause / USB sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= player_pkg::ST_BOOT;
        end else begin
            case (state_r)
                player_pkg::ST_BOOT: begin
                    if (boot_done) begin
                        state_r <= player_pkg::ST_PLAY;
                    end
                end
                player_pkg::ST_PLAY: begin
                    if (short_p[player_pkg::K_PWR]) begin
                        state_r <= player_pkg::ST_PAUSE;
                    end
                end
                player_pkg::ST_PAUSE: begin
                    if (short_p[player_pkg::K_PWR]) begin
                        state_r <= player_pkg::ST_PLAY;
                    end else if (tick && pause_cnt_r == player_pkg::PAUSE_LP_SMP - 8'h01) begin
                        state_r <= player_pkg::ST_LOWPWR;
                    end
                end
                player_pkg::ST_LOWPWR: begin
                    if (short_p[player_pkg::K_PWR]) begin
                        state_r <= player_pkg::ST_PLAY;
                    end
                end
                player_pkg::ST_USB: begin
                    if (!usb_attach_det) begin
                        state_r <= player_pkg::ST_PLAY;
                    end
                end
                default: begin
                    state_r <= player_pkg::ST_BOOT;
                end
            endcase
            // Attach overrides any player state except ST_BOOT
            if (usb_attach_det && !usb_det_r && state_r != player_pkg::ST_BOOT) begin
                state_r <= player_pkg::ST_USB;
            end
        end
    end

    // Pause duration and played time, both in samples
    always_ff @(posedge core_clk) begin
        if (rst || state_r != player_pkg::ST_PAUSE) begin
            pause_cnt_r <= 8'h00;
        end else if (tick && pause_cnt_r != player_pkg::CNT_MAX) begin
            pause_cnt_r <= pause_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || song_change) begin
            play_time_r <= 8'h00;
        end else if (tick && state_r == player_pkg::ST_PLAY && play_time_r != player_pkg::CNT_MAX) begin
            play_time_r <= play_time_r + 8'h01;
        end
    end

    // Blink phase for the paused power LED
    always_ff @(posedge core_clk) begin
        if (rst) begin
            blink_cnt_r <= 8'h00;
            blink_r <= 1'b0;
        end else if (tick) begin
            if (blink_cnt_r == player_pkg::BLINK_SMP - 8'h01) begin
                blink_cnt_r <= 8'h00;
                blink_r <= !blink_r;
            end else begin
                blink_cnt_r <= blink_cnt_r + 8'h01;
            end
        end
    end

    // LEDs go out on the serial pins while the player runs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            power_led <= 1'b0;
            feature_led <= 1'b0;
            low_power <= 1'b0;
        end else begin
            power_led <= (state_r == player_pkg::ST_PAUSE || state_r == player_pkg::ST_LOWPWR) ? blink_r
                : (state_r != player_pkg::ST_BOOT);
            feature_led <= random_r;
            low_power <= state_r == player_pkg::ST_LOWPWR;
        end
    end

    // ==========================================================
    // Key actions
    logic player_on;
    assign player_on = state_r == player_pkg::ST_PLAY || state_r == player_pkg::ST_PAUSE
        || state_r == player_pkg::ST_LOWPWR;

    // Volume: one half-dB step per short press or per held sample
    always_ff @(posedge core_clk) begin
        if (rst) begin
            volume <= player_pkg::VOL_RESET;
        end else if (apb_wr && paddr == player_pkg::A_VOLUME) begin
            volume <= pwdata[7:0];
        end else if (player_on) begin
            if ((short_p[player_pkg::K_VUP] || (tick && long_held[player_pkg::K_VUP]))
                && volume != player_pkg::VOL_MAX) begin
                volume <= volume + 8'h01;
            end else if ((short_p[player_pkg::K_VDN] || (tick && long_held[player_pkg::K_VDN]))
                && volume != player_pkg::VOL_MIN) begin
                volume <= volume - 8'h01;
            end
        end
    end

    // Random play and spatial mode from the feature key
    always_ff @(posedge core_clk) begin
        if (rst) begin
            random_r <= 1'b0;
            spatial_mode <= player_pkg::SP_OFF;
        end else if (player_on) begin
            if (long_p[player_pkg::K_FEAT]) begin
                random_r <= !random_r;
            end
            if (short_p[player_pkg::K_FEAT]) begin
                spatial_mode <= spatial_mode + 2'h1;
            end
        end
    end

    // Action strobes towards the player firmware; one cycle each, except rewind and fast_fwd, which stay high while the key is held long
    always_ff @(posedge core_clk) begin
        if (rst) begin
            act <= '0;
        end else begin
            act.restart_song <= player_on && short_p[player_pkg::K_PREV]
                && play_time_r >= player_pkg::RESTART_SMP;
            act.prev_song <= player_on && short_p[player_pkg::K_PREV]
                && play_time_r < player_pkg::RESTART_SMP;
            act.next_song <= player_on && short_p[player_pkg::K_NEXT];
            act.rewind <= player_on && long_held[player_pkg::K_PREV];
            act.fast_fwd <= player_on && long_held[player_pkg::K_NEXT];
            act.random_pick <= player_on && long_p[player_pkg::K_FEAT] && !random_r;
            act.power_down <= player_on && power_off_p;
            act.stop_play <= usb_attach_det && !usb_det_r;
            act.usb_init <= usb_attach_det && !usb_det_r;
        end
    end

    // ==========================================================
    // USB attach and straps
    logic strap_done_r;
    logic class_strap_r;
    logic flash_strap_r;

    // Straps caught once, in the first cycle after reset release
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strap_done_r <= 1'b0;
            class_strap_r <= 1'b0;
            flash_strap_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            class_strap_r <= usb_class_strap_pin;
            flash_strap_r <= flash_select_strap;
        end
    end

    // Attach turns on fast clock, 3.6 V supply and pull-up as one group
    always_ff @(posedge core_clk) begin
        if (rst) begin
            usb_det_r <= 1'b0;
            usb_active_r <= 1'b0;
            usb_pullup_en <= 1'b0;
            clk_48m_sel <= 1'b0;
            avdd_3v6_sel <= 1'b0;
            usb_audio_class <= 1'b0;
            use_flash_disk <= 1'b0;
        end else begin
            usb_det_r <= usb_attach_det;
            usb_active_r <= usb_attach_det;
            usb_pullup_en <= usb_active_r;
            clk_48m_sel <= usb_active_r;
            avdd_3v6_sel <= usb_active_r;
            usb_audio_class <= class_strap_r;
            use_flash_disk <= flash_strap_r && ctrl_r[player_pkg::C_SECTOR_OK];
        end
    end

    // ==========================================================
    // Audio settings
    logic [15:0] rate_req_r;
    logic [7:0] gain_tag_r;

    // Rate clamp only while USB runs the slow clock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            play_rate <= player_pkg::RATE_RESET;
            applied_gain <= player_pkg::GAIN_DEFAULT;
        end else begin
            play_rate <= (usb_active_r && ctrl_r[player_pkg::C_CLK12] && rate_req_r > player_pkg::RATE_CLAMP)
                ? player_pkg::RATE_CLAMP : rate_req_r;
            applied_gain <= ctrl_r[player_pkg::C_TAG_VALID] ? gain_tag_r
                : player_pkg::GAIN_DEFAULT;
        end
    end

    // ==========================================================
    // APB slave, zero wait states
    logic mapped;
    logic mon_set;
    logic mon_clr;
    assign apb_wr = psel && penable && pwrite;
    assign mapped = paddr == player_pkg::A_CTRL || paddr == player_pkg::A_STATUS
        || paddr == player_pkg::A_VOLUME || paddr == player_pkg::A_RXBYTE
        || paddr == player_pkg::A_RATE || paddr == player_pkg::A_GAIN
        || paddr == player_pkg::A_PLAYTIME;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign mon_set = apb_wr && paddr == player_pkg::A_RXBYTE && pwdata[7:0] == player_pkg::MONITOR_BYTE;
    assign mon_clr = apb_wr && paddr == player_pkg::A_CTRL && pwdata[player_pkg::C_MON_CLR];

    // Writable control and setting registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r <= '0;
            rate_req_r <= player_pkg::RATE_RESET;
            gain_tag_r <= player_pkg::GAIN_DEFAULT;
        end else if (apb_wr) begin
            if (paddr == player_pkg::A_CTRL) begin
                ctrl_r <= {1'b0, pwdata[player_pkg::C_WIDTH-1:0]};
            end
            if (paddr == player_pkg::A_RATE) begin
                rate_req_r <= pwdata[15:0];
            end
            if (paddr == player_pkg::A_GAIN) begin
                gain_tag_r <= pwdata[7:0];
            end
        end
    end

    // Monitor entry; a matching byte wins over a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            monitor_mode <= 1'b0;
        end else if (mon_set) begin
            monitor_mode <= 1'b1;
        end else if (mon_clr) begin
            monitor_mode <= 1'b0;
        end
    end

    // Read data latched in the setup phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            case (paddr)
                player_pkg::A_CTRL: prdata <= {26'h0, ctrl_r};
                player_pkg::A_STATUS: prdata <= {16'h0, 2'h0, spatial_mode, usb_audio_class,
                    use_flash_disk, usb_active_r, random_r, monitor_mode, flash_busy, key_lvl_r};
                player_pkg::A_VOLUME: prdata <= {24'h0, volume};
                player_pkg::A_RATE: prdata <= {16'h0, play_rate};
                player_pkg::A_GAIN: prdata <= {24'h0, applied_gain};
                player_pkg::A_PLAYTIME: prdata <= {21'h0, state_r, play_time_r};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_busy_hold;
        flash_busy && $past(flash_busy) |=> $stable(key_lvl_r);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("keys sampled during flash use");

    property p_vol_up;
        player_on && short_p[player_pkg::K_VUP] && !short_p[player_pkg::K_VDN] && volume != player_pkg::VOL_MAX
            && !(apb_wr && paddr == player_pkg::A_VOLUME) |=> volume == $past(volume) + 8'h01;
    endproperty
    a_vol_up: assert property (p_vol_up) else $error("volume up step wrong");

    property p_long_at;
        long_p[player_pkg::K_FEAT] |-> held_r[player_pkg::K_FEAT] == player_pkg::LONG_SMP - 8'h01
            && key_lvl_r[player_pkg::K_FEAT];
    endproperty
    a_long_at: assert property (p_long_at) else $error("long press at wrong time");

    property p_power_off;
        act.power_down |-> $past(held_r[player_pkg::K_PWR]) == player_pkg::POWER_SMP - 8'h01;
    endproperty
    a_power_off: assert property (p_power_off) else $error("power off not at two seconds");

    property p_led_play;
        state_r == player_pkg::ST_PLAY ##1 state_r == player_pkg::ST_PLAY |-> power_led;
    endproperty
    a_led_play: assert property (p_led_play) else $error("power LED dark while playing");

    property p_lowpwr;
        state_r == player_pkg::ST_PAUSE && tick && pause_cnt_r == player_pkg::PAUSE_LP_SMP - 8'h01
            && !short_p[player_pkg::K_PWR] && !(usb_attach_det && !usb_det_r)
            |=> state_r == player_pkg::ST_LOWPWR;
    endproperty
    a_lowpwr: assert property (p_lowpwr) else $error("low-power pause missed");

    property p_random;
        player_on && long_p[player_pkg::K_FEAT] && !random_r |=> act.random_pick ##1 feature_led;
    endproperty
    a_random: assert property (p_random) else $error("random on without pick");

    property p_restart;
        player_on && short_p[player_pkg::K_PREV] && play_time_r >= player_pkg::RESTART_SMP
            |=> act.restart_song && !act.prev_song;
    endproperty
    a_restart: assert property (p_restart) else $error("restart rule broken");

    property p_usb;
        usb_attach_det && !usb_det_r ##1 usb_attach_det |=> usb_pullup_en && clk_48m_sel && avdd_3v6_sel;
    endproperty
    a_usb: assert property (p_usb) else $error("USB attach sequence wrong");

    property p_monitor;
        mon_set |=> monitor_mode;
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor entry lost");

    property p_clamp;
        usb_active_r && ctrl_r[player_pkg::C_CLK12] |=> play_rate <= player_pkg::RATE_CLAMP;
    endproperty
    a_clamp: assert property (p_clamp) else $error("rate not clamped");
endmodule

// File: dv/key_panel.sv
`timescale 1ns/1ps
// ==========================================================
// Person at the keys, plus strap resistors
module key_panel (
    input wire logic [5:0] hold_req,
    input wire logic strap_up,
    output logic [4:0] key_input_lines,
    output logic power_key,
    output logic usb_class_strap_pin,
    output logic flash_select_strap
);
    // Released keys fall to the pull-down level
    assign key_input_lines = hold_req[4:0];
    assign power_key = hold_req[5];
    // Both straps pulled up when strap_up, else pulled down
    assign usb_class_strap_pin = strap_up;
    assign flash_select_strap = strap_up;
endmodule

// File: dv/player_control_front_end_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the player control front end
module player_control_front_end_tb_top;
    localparam int DIV = 8;
    typedef struct packed {
        logic [5:0] key;
        logic [7:0] ticks;
        logic [7:0] vol;
        logic [1:0] sp;
        logic [8:0] act;
    } row_t;
    logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, volume, applied_gain;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, usb_attach_det = 1'b0, act_clr = 1'b0, strap_up = 1'b1;
    logic [5:0] hold_req = 6'h00;
    logic [4:0] key_input_lines;
    logic power_key, usb_class_strap_pin, flash_select_strap, power_led, feature_led, usb_pullup_en;
    logic clk_48m_sel, avdd_3v6_sel, usb_audio_class, use_flash_disk, monitor_mode, low_power;
    logic [1:0] spatial_mode;
    logic [15:0] play_rate;
    player_pkg::action_t act;
    logic [8:0] act_seen = 9'h000;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    row_t rows[11] = '{'{6'h02, 8'h02, 8'hc1, 2'h0, 9'h000}, '{6'h01, 8'h02, 8'hc0, 2'h0, 9'h000},
        '{6'h08, 8'h02, 8'hc0, 2'h0, 9'h080}, '{6'h10, 8'h02, 8'hc0, 2'h1, 9'h000},
        '{6'h10, 8'h14, 8'hc0, 2'h1, 9'h008}, '{6'h08, 8'h14, 8'hc0, 2'h1, 9'h010},
        '{6'h04, 8'h02, 8'hc0, 2'h1, 9'h100}, '{6'h04, 8'h14, 8'hc0, 2'h1, 9'h020},
        '{6'h08, 8'h50, 8'hc0, 2'h1, 9'h010}, '{6'h04, 8'h02, 8'hc0, 2'h1, 9'h040},
        '{6'h02, 8'h14, 8'hc4, 2'h1, 9'h000}};

    key_panel panel (.hold_req(hold_req), .strap_up(strap_up), .key_input_lines(key_input_lines),
        .power_key(power_key),
        .usb_class_strap_pin(usb_class_strap_pin), .flash_select_strap(flash_select_strap));
    player_control_front_end #(.SAMPLE_DIV(DIV)) dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_input_lines(key_input_lines), .power_key(power_key),
        .usb_attach_det(usb_attach_det), .usb_class_strap_pin(usb_class_strap_pin),
        .flash_select_strap(flash_select_strap), .power_led(power_led), .feature_led(feature_led),
        .usb_pullup_en(usb_pullup_en), .clk_48m_sel(clk_48m_sel), .avdd_3v6_sel(avdd_3v6_sel),
        .usb_audio_class(usb_audio_class), .use_flash_disk(use_flash_disk), .monitor_mode(monitor_mode),
        .low_power(low_power), .volume(volume), .spatial_mode(spatial_mode), .play_rate(play_rate),
        .applied_gain(applied_gain), .act(act));

    initial forever #10 core_clk = ~core_clk;

    // ==========================================================
    // Pulse catcher, so one-cycle actions are never missed; hang guard
    always @(posedge core_clk) begin
        act_seen <= act_clr ? 9'h000 : act_seen | act;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // Hold keys for whole sample ticks, then settle
    task automatic press(input logic [5:0] k, input int t);
        act_clr <= 1'b1;
        @(posedge core_clk);
        act_clr <= 1'b0;
        hold_req <= k;
        repeat (t * DIV) @(posedge core_clk);
        hold_req <= 6'h00;
        repeat (3 * DIV) @(posedge core_clk);
    endtask

    task automatic complete_run;
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(32'(applied_gain), 32'hf4);
        chk(32'(play_rate), 32'hac44);
        chk(32'(power_led), 32'h0);
        apb(1'b1, player_pkg::A_CTRL, 32'h1);
        repeat (4) @(posedge core_clk);
        chk(32'(power_led), 32'h1);
        foreach (rows[i]) begin
            press(rows[i].key, 32'(rows[i].ticks));
            chk(32'(volume), 32'(rows[i].vol));
            chk(32'(spatial_mode), 32'(rows[i].sp));
            chk(32'(act_seen), 32'(rows[i].act));
        end
        chk(32'(feature_led), 32'h1);
        apb(1'b0, player_pkg::A_VOLUME, 32'h0);
        chk(rd, 32'hc4);
        // Pause: blink phase flips every four samples
        press(6'h20, 2);
        err = power_led;
        repeat (4 * DIV) @(posedge core_clk);
        chk(32'(power_led), 32'(!err));
        repeat (50 * DIV) @(posedge core_clk);
        chk(32'(low_power), 32'h1);
        press(6'h20, 2);
        chk(32'(low_power), 32'h0);
        usb_attach_det <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(32'({usb_pullup_en, clk_48m_sel, avdd_3v6_sel}), 32'h7);
        chk(32'({usb_audio_class, use_flash_disk}), 32'h2);
        chk(32'(act_seen), 32'h3);
        // Slow clock, tag gain and a valid sector while attached
        apb(1'b1, player_pkg::A_RATE, 32'hbb80);
        apb(1'b1, player_pkg::A_GAIN, 32'h10);
        apb(1'b1, player_pkg::A_CTRL, 32'h1d);
        @(posedge core_clk);
        chk(32'(play_rate), 32'hb71b);
        chk(32'(applied_gain), 32'h10);
        chk(32'({usb_audio_class, use_flash_disk}), 32'h3);
        usb_attach_det <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'({usb_pullup_en, clk_48m_sel, avdd_3v6_sel}), 32'h0);
        chk(32'(play_rate), 32'hbb80);
        apb(1'b1, player_pkg::A_RXBYTE, 32'hef);
        chk(32'(monitor_mode), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        // Keys ignored while the lines carry flash traffic
        apb(1'b1, player_pkg::A_CTRL, 32'h1f);
        press(6'h02, 2);
        chk(32'(volume), 32'hc4);
        apb(1'b1, player_pkg::A_CTRL, 32'h3d);
        chk(32'(monitor_mode), 32'h0);
        press(6'h20, 33);
        chk(32'(act_seen[2]), 32'h1);
        // Second reset with both straps pulled down
        strap_up <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        chk(32'(volume), 32'hc0);
        chk(32'(power_led), 32'h0);
        apb(1'b1, player_pkg::A_CTRL, 32'h5);
        @(posedge core_clk);
        chk(32'({usb_audio_class, use_flash_disk}), 32'h0);
        complete_run;
    end
endmodule
